/* dv/rffrt_checker.sv */
/* port assertions of the frame filter top.
   assumes the bind below attaches it to every instance. */
`timescale 1ns/1ps
module rffrt_checker #(
    parameter int MAX_FRAME_BYTES = 127
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous reset
    input wire rffrt_pkg::rffrt_reg_req_t regReq, // register access
    input wire logic regRdValid, // read data valid
    input wire rffrt_pkg::rffrt_rx_t rxIn, // byte stream
    input wire logic frameEndEvent, // end event
    input wire logic addrMatchEvent, // match event
    input wire logic ackSend, // ack request
    input wire logic rxFcsValid, // checksum flag
    input wire logic txTimestampEnable // control bit 7
);
    // one clock domain, so one default clock and reset
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    rd_answer_a: assert property (regReq.rd |=> regRdValid)
        else $error("read not answered next cycle");
    rd_only_a: assert property (regRdValid |-> $past(regReq.rd))
        else $error("read valid without a read");
    ctrl_bit_a: assert property (regReq.wr &&
        regReq.addr == rffrt_pkg::ADDR_EXT_RX_CTRL |=>
        txTimestampEnable == $past(regReq.wdata[7]))
        else $error("control bit 7 not taken");
    end_cause_a: assert property (frameEndEvent |-> $past(rxIn.done))
        else $error("end event without frame done");
    fcs_flag_a: assert property ($past(rxIn.done) |->
        rxFcsValid == $past(rxIn.fcsOk))
        else $error("checksum flag wrong");
    ack_end_a: assert property (ackSend |-> frameEndEvent && rxFcsValid)
        else $error("ack without good frame end");
    end_pulse_a: assert property (frameEndEvent |=> !frameEndEvent)
        else $error("end event longer than a cycle");
    match_pulse_a: assert property (addrMatchEvent |=> !addrMatchEvent)
        else $error("match event longer than a cycle");
    cover property (frameEndEvent);
    cover property (addrMatchEvent);
    cover property (ackSend);
endmodule
bind rffrt_frame_filter rffrt_checker #(.MAX_FRAME_BYTES(MAX_FRAME_BYTES))
    chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq),
    .regRdValid(regRdValid), .rxIn(rxIn), .frameEndEvent(frameEndEvent),
    .addrMatchEvent(addrMatchEvent), .ackSend(ackSend),
    .rxFcsValid(rxFcsValid), .txTimestampEnable(txTimestampEnable));

/* dv/rffrt_radio_model.sv */
/* receiver side model: hands one frame's bytes to the filter.
   assumes the bench calls send_frame from its main process. */
`timescale 1ns/1ps
module rffrt_radio_model (
    input wire logic clk_sys, // system clock
    output rffrt_pkg::rffrt_rx_t rxIn // byte stream to the filter
);
    initial rxIn = '0;
    // idle data is the inverse of the last byte up to done, then a copy of the last byte
    task automatic send_frame(input logic [7:0] b[11], input logic ok);
        @(posedge clk_sys) rxIn <= '{1'h1, 1'h0, 8'h00, 1'h0, 1'h0};
        foreach (b[i]) begin
            @(posedge clk_sys) rxIn <= '{1'h0, 1'h1, b[i], 1'h0, 1'h0};
        end
        @(posedge clk_sys) rxIn <= '{1'h0, 1'h0, ~b[10], 1'h0, 1'h0};
        // checksum verdict rides on done only
        @(posedge clk_sys) rxIn <= '{1'h0, 1'h0, ~b[10], 1'h1, ok};
        @(posedge clk_sys) rxIn <= '{1'h0, 1'h0, b[10], 1'h0, 1'h0};
    endtask
endmodule

/* dv/rx_frame_filter_reserved_types_test.sv */
/* bench of the frame filter: registers, reserved types, promiscuous.
   assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module rx_frame_filter_reserved_types_test;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    rffrt_pkg::rffrt_reg_req_t regReq = '0;
    logic [7:0] regRdData;
    logic regRdValid, frameEndEvent, addrMatchEvent, ackSend, rxFcsValid;
    rffrt_pkg::rffrt_rx_t rxIn;
    logic [2:0] seen = '0; // match, end, ack seen during a frame
    logic clrSeen = 1'h1; // holds seen at zero between frames
    logic tsEn, ackTime, spcEn; // control bits of the extended register
    int err_total = 0;
    int cmp_count = 0;
    // {0x17 value, dst match, fcs ok, match end ack expected}
    logic [12:0] t[7] = '{{8'h00, 2'h3, 3'h0}, {8'h10, 2'h1, 3'h2},
        {8'h10, 2'h2, 3'h0}, {8'h30, 2'h3, 3'h7}, {8'h30, 2'h1, 3'h0},
        {8'h30, 2'h2, 3'h4}, {8'h02, 2'h0, 3'h2}};
    rffrt_frame_filter dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
        .rxAackActive(1'h1), .rxIn(rxIn), .frameEndEvent(frameEndEvent),
        .addrMatchEvent(addrMatchEvent), .ackSend(ackSend),
        .rxFcsValid(rxFcsValid), .txTimestampEnable(tsEn),
        .ackTurnaroundSelect(ackTime), .smartPowerEnable(spcEn));
    rffrt_radio_model radio_u (.clk_sys(clk_sys), .rxIn(rxIn));
    // one process owns seen; the bench only steers the clear
    always @(posedge clk_sys) seen <= clrSeen ? 3'h0 : seen |
        {addrMatchEvent, frameEndEvent, ackSend};
    task automatic check(input string s, input logic [7:0] g, e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic complete_run(input logic hang);
        if (hang) err_total++;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_sys) regReq <= '{1'h1, 1'h0, a, d};
        @(posedge clk_sys) regReq <= '0;
    endtask
    // bounded wait for the read answer; a hang ends the run
    task automatic rd_chk(input logic [7:0] a, e);
        int n;
        @(posedge clk_sys) regReq <= '{1'h0, 1'h1, a, 8'h00};
        @(posedge clk_sys) regReq <= '0;
        #1;
        for (n = 0; n < 4 && regRdValid !== 1'h1; n++) @(posedge clk_sys) #1;
        if (n == 4) complete_run(1'h1);
        check("read data", regRdData, e);
    endtask
    initial forever #10 clk_sys = ~clk_sys;
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        rd_chk(8'h17, 8'h00);
        rd_chk(8'h2E, 8'h41);
        rd_chk(8'h40, 8'h00);
        wr(8'h17, 8'hFF);
        rd_chk(8'h17, 8'hF7);
        check("control outs", {5'h00, tsEn, ackTime, spcEn}, 8'h07);
        wr(8'h2E, 8'hC8);
        rd_chk(8'h2E, 8'hC8);
        wr(8'h20, 8'h34);
        wr(8'h21, 8'h12);
        $display("register test done");
        for (int i = 0; i < 7; i++) begin
            clrSeen <= 1'h1;
            wr(8'h17, t[i][12:5]);
            clrSeen <= 1'h0;
            radio_u.send_frame('{8'h64, 8'h88, 8'h01, 8'hFF, 8'hFF,
                t[i][4] ? 8'h34 : 8'h35, 8'h12, 8'h01, 8'h00, 8'hA5,
                8'h5A}, t[i][3]);
            repeat (2) @(posedge clk_sys);
            #1;
            check("events", {5'h00, seen}, {5'h00, t[i][2:0]});
            check("fcs flag", {7'h00, rxFcsValid}, {7'h00, t[i][3]});
            $display("frame test %0d done", i);
        end
        complete_run(1'h0);
    end
endmodule

/* inc/rffrt_pkg.sv */
/*
  constants, frame-control decoding and carrier types of the receive
  frame filter. assumes a receiver that hands over psdu bytes in order,
  first byte of the frame control field first.
*/
package rffrt_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_EXT_RX_CTRL = 8'h17;
    localparam logic [7:0] ADDR_SHORT_LO = 8'h20;
    localparam logic [7:0] ADDR_SHORT_HI = 8'h21;
    localparam logic [7:0] ADDR_NETID_LO = 8'h22;
    localparam logic [7:0] ADDR_NETID_HI = 8'h23;
    localparam logic [7:0] ADDR_EXT_FIRST = 8'h24;
    localparam logic [7:0] ADDR_EXT_LAST = 8'h2B;
    localparam logic [7:0] ADDR_ACK_FILT_CTRL = 8'h2E;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_TX_TS_EN = 7;
    localparam int BIT_RSVD_FILTER = 5;
    localparam int BIT_RSVD_UPLOAD = 4;
    localparam int BIT_ACK_TIME = 2;
    localparam int BIT_PROMISC = 1;
    localparam int BIT_SMART_PWR = 0;
    localparam int BIT_FVN_LSB = 6;
    localparam int BIT_ACK_DISABLE = 4;
    localparam int BIT_COORD = 3;
    // bit 3 of the extended control register is read-only zero
    localparam logic [7:0] EXT_RX_CTRL_WMASK = 8'hF7;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] EXT_RX_CTRL_RST = 8'h00;
    localparam logic [7:0] ACK_FILT_CTRL_RST = 8'h41;
    localparam logic [15:0] SHORT_ADDR_RST = 16'hFFFF;
    localparam logic [15:0] NETID_RST = 16'hFFFF;
    localparam logic [63:0] EXT_ADDR_RST = 64'h0000000000000000;

    // ----------------------------------------------------------------
    // frame control field
    // ----------------------------------------------------------------
    localparam logic [2:0] FT_BEACON = 3'h0;
    localparam logic [2:0] FT_DATA = 3'h1;
    localparam logic [2:0] FT_ACK = 3'h2;
    localparam logic [2:0] FT_CMD = 3'h3;
    localparam logic [1:0] AM_NONE = 2'h0;
    localparam logic [1:0] AM_SHORT = 2'h2;
    localparam logic [1:0] AM_EXT = 2'h3;
    localparam logic [1:0] FVN_ANY = 2'h3;
    localparam int FCF_ACKREQ_BIT = 5;
    localparam int FCF_PANCOMP_BIT = 6;
    localparam int FCF_DMODE_LSB = 10;
    localparam int FCF_VER_LSB = 12;
    localparam int FCF_SMODE_LSB = 14;
    localparam logic [15:0] BROADCAST = 16'hFFFF;
    localparam logic [6:0] HDR_BASE = 7'h03;
    localparam logic [6:0] PAN_LEN = 7'h02;
    localparam logic [6:0] SHORT_LEN = 7'h02;
    localparam logic [6:0] EXT_LEN = 7'h08;

    typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_PAYLOAD} rffrt_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rffrt_reg_req_t;

    typedef struct packed {
        logic start;
        logic valid;
        logic [7:0] data;
        logic done;
        logic fcsOk;
    } rffrt_rx_t;

    typedef struct packed {
        logic [15:0] shortAddr;
        logic [15:0] panId;
        logic [63:0] extAddr;
        logic promisc;
        logic upload;
        logic filtering;
        logic coord;
        logic ackDisable;
        logic [1:0] fvnMode;
    } rffrt_cfg_t;

    typedef struct packed {
        logic [15:0] fcf;
        logic [15:0] dstPan;
        logic [63:0] dstAddr;
        logic [15:0] srcPan;
    } rffrt_hdr_t;

    typedef struct packed {
        logic amiOk;
        logic endOk;
        logic ackOk;
    } rffrt_verdict_t;

    // byte length of an address field for a given addressing mode
    function automatic logic [6:0] addrLen(input logic [1:0] mode);
        case (mode)
            AM_SHORT: addrLen = SHORT_LEN;
            AM_EXT: addrLen = EXT_LEN;
            default: addrLen = 7'h00;
        endcase
    endfunction
endpackage

/* logic/rffrt_filter_decide.sv */
/*
  combinational verdict of the frame filter for one parsed header.
  assumes the header fields are stable and hdrComplete is high only
  once every address byte has been captured.
*/
`timescale 1ns/1ps
module rffrt_filter_decide (
    input wire rffrt_pkg::rffrt_hdr_t hdr, // captured header fields
    input wire rffrt_pkg::rffrt_cfg_t cfg, // programmed configuration
    input wire logic hdrComplete, // all address bytes seen
    input wire logic fcsOk, // checksum result of the frame
    output rffrt_pkg::rffrt_verdict_t verdict // interrupt and ack gating
);
    logic [2:0] fType;
    logic [1:0] dMode;
    logic [1:0] sMode;
    logic [1:0] ver;
    logic reserved;
    logic asData;
    logic uploadOnly;
    logic dataLike;
    logic verOk;
    logic dPanOk;
    logic dAddrOk;
    logic beaconOk;
    logic srcOnlyOk;
    logic addrPass;
    logic amiQuiet;
    logic [15:0] srcPanEff;

    // ----------------------------------------------------------------
    // address filter and reserved-type policy
    // ----------------------------------------------------------------
    always_comb begin
        fType = hdr.fcf[2:0];
        dMode = hdr.fcf[rffrt_pkg::FCF_DMODE_LSB +: 2];
        sMode = hdr.fcf[rffrt_pkg::FCF_SMODE_LSB +: 2];
        ver = hdr.fcf[rffrt_pkg::FCF_VER_LSB +: 2];
        reserved = fType[2];
        // filtering without upload is a misuse; treat it as discard
        asData = reserved & cfg.upload & cfg.filtering;
        uploadOnly = reserved & cfg.upload & ~cfg.filtering;
        dataLike = (fType == rffrt_pkg::FT_DATA) ||
                   (fType == rffrt_pkg::FT_CMD) || asData;
        verOk = (cfg.fvnMode == rffrt_pkg::FVN_ANY) ||
                (ver <= cfg.fvnMode);
        srcPanEff = hdr.fcf[rffrt_pkg::FCF_PANCOMP_BIT] ?
                    hdr.dstPan : hdr.srcPan;
        dPanOk = (dMode < rffrt_pkg::AM_SHORT) ||
                 (hdr.dstPan == cfg.panId) ||
                 (hdr.dstPan == rffrt_pkg::BROADCAST);
        case (dMode)
            rffrt_pkg::AM_SHORT: dAddrOk =
                (hdr.dstAddr[15:0] == cfg.shortAddr) ||
                (hdr.dstAddr[15:0] == rffrt_pkg::BROADCAST);
            rffrt_pkg::AM_EXT: dAddrOk =
                (hdr.dstAddr == cfg.extAddr);
            default: dAddrOk = 1'b1;
        endcase
        beaconOk = (fType != rffrt_pkg::FT_BEACON) ||
                   (sMode < rffrt_pkg::AM_SHORT) ||
                   (cfg.panId == rffrt_pkg::BROADCAST) ||
                   (srcPanEff == cfg.panId);
        // source-only data or command frames need the coordinator role
        srcOnlyOk = !(dataLike && (dMode == rffrt_pkg::AM_NONE) &&
                      (sMode >= rffrt_pkg::AM_SHORT)) ||
                    (cfg.coord && (srcPanEff == cfg.panId));
        addrPass = hdrComplete && (!reserved || asData) && verOk &&
                   dPanOk && dAddrOk && beaconOk && srcOnlyOk &&
                   (fType != rffrt_pkg::FT_ACK) &&
                   ((dMode >= rffrt_pkg::AM_SHORT) ||
                    (sMode >= rffrt_pkg::AM_SHORT));
        // acknowledgement-like addressing is never announced
        amiQuiet = (dMode <= 2'h1) && (sMode == rffrt_pkg::AM_NONE);
        verdict.amiOk = addrPass && !amiQuiet;
        if (cfg.promisc) begin
            verdict.endOk = 1'b1;
        end else if (uploadOnly) begin
            verdict.endOk = fcsOk;
        end else begin
            verdict.endOk = addrPass && fcsOk;
        end
        // ack only for frames that pass and ended with a good checksum
        verdict.ackOk = !cfg.ackDisable && !uploadOnly && addrPass &&
                        fcsOk && hdr.fcf[rffrt_pkg::FCF_ACKREQ_BIT];
    end
endmodule

/* logic/rffrt_frame_filter.sv */
/*
  receive frame filter of the auto-acknowledge receive state: address
  and control registers, header parser and event generation.
  assumes register requests and the psdu byte stream come from logic
  on clk_sys; a frame is framed by start and done strobes, done carries
  the checksum result and follows the last byte.
*/
`timescale 1ns/1ps
module rffrt_frame_filter #(
    parameter int MAX_FRAME_BYTES = 127
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous reset
    input wire rffrt_pkg::rffrt_reg_req_t regReq, // register access
    output logic [7:0] regRdData, // read data
    output logic regRdValid, // read data valid
    input wire logic rxAackActive, // auto-ack receive state active
    input wire rffrt_pkg::rffrt_rx_t rxIn, // received byte stream
    output logic frameEndEvent, // frame end event pulse
    output logic addrMatchEvent, // address match event pulse
    output logic ackSend, // start automatic acknowledgement
    output logic rxFcsValid, // checksum result of last frame
    output logic txTimestampEnable, // control bit to tx side
    output logic ackTurnaroundSelect, // control bit to ack timer
    output logic smartPowerEnable // control bit to receiver
);
    // ----------------------------------------------------------------
    // state and configuration checks
    // ----------------------------------------------------------------
    initial begin
        if (MAX_FRAME_BYTES < 4 || MAX_FRAME_BYTES > 127) begin
            $error("frame length must fit the 7-bit byte counter");
        end
    end

    localparam logic [6:0] MAX_POS = 7'(MAX_FRAME_BYTES);

    typedef struct packed {
        rffrt_pkg::rffrt_state_t st;
        logic [6:0] pos;
        rffrt_pkg::rffrt_hdr_t hdr;
        logic [7:0] extRxCtrl;
        logic [7:0] ackFiltCtrl;
        logic [15:0] shortAddr;
        logic [15:0] panId;
        logic [63:0] extAddr;
        logic [7:0] rdData;
        logic rdValid;
        logic frameEnd;
        logic addrMatch;
        logic ackSend;
        logic fcsValid;
    } rffrt_core_t;

    rffrt_core_t core_ff;
    rffrt_core_t nxt_core;
    rffrt_pkg::rffrt_cfg_t cfg;
    rffrt_pkg::rffrt_verdict_t verdict;
    logic hdrComplete;
    logic hdrNow;
    logic [1:0] dMode;
    logic [1:0] sMode;
    logic [6:0] dPanLen;
    logic [6:0] sPanLen;
    logic [6:0] dAddrStart;
    logic [6:0] sPanStart;
    logic [6:0] hdrLen;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // byte lane of the extended address for a register offset
    function automatic logic [2:0] extIndex(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - rffrt_pkg::ADDR_EXT_FIRST;
        extIndex = diff[2:0];
    endfunction

    function automatic logic isExtAddr(input logic [7:0] addr);
        isExtAddr = (addr >= rffrt_pkg::ADDR_EXT_FIRST) &&
                    (addr <= rffrt_pkg::ADDR_EXT_LAST);
    endfunction

    // ----------------------------------------------------------------
    // configuration view of the registers
    // ----------------------------------------------------------------
    always_comb begin
        cfg.shortAddr = core_ff.shortAddr;
        cfg.panId = core_ff.panId;
        cfg.extAddr = core_ff.extAddr;
        cfg.promisc = core_ff.extRxCtrl[rffrt_pkg::BIT_PROMISC];
        cfg.upload = core_ff.extRxCtrl[rffrt_pkg::BIT_RSVD_UPLOAD];
        cfg.filtering =
            core_ff.extRxCtrl[rffrt_pkg::BIT_RSVD_FILTER];
        cfg.coord = core_ff.ackFiltCtrl[rffrt_pkg::BIT_COORD];
        cfg.ackDisable = core_ff.ackFiltCtrl[rffrt_pkg::BIT_ACK_DISABLE];
        cfg.fvnMode =
            core_ff.ackFiltCtrl[rffrt_pkg::BIT_FVN_LSB +: 2];
    end

    // ----------------------------------------------------------------
    // header geometry from the captured frame control field
    // ----------------------------------------------------------------
    // network id compression only drops the source id when both present
    always_comb begin
        dMode = core_ff.hdr.fcf[rffrt_pkg::FCF_DMODE_LSB +: 2];
        sMode = core_ff.hdr.fcf[rffrt_pkg::FCF_SMODE_LSB +: 2];
        dPanLen = (dMode >= rffrt_pkg::AM_SHORT) ?
                  rffrt_pkg::PAN_LEN : 7'h00;
        sPanLen = ((sMode >= rffrt_pkg::AM_SHORT) &&
                   !(core_ff.hdr.fcf[rffrt_pkg::FCF_PANCOMP_BIT] &&
                     (dMode >= rffrt_pkg::AM_SHORT))) ?
                  rffrt_pkg::PAN_LEN : 7'h00;
        dAddrStart = rffrt_pkg::HDR_BASE + dPanLen;
        sPanStart = dAddrStart + rffrt_pkg::addrLen(dMode);
        hdrLen = sPanStart + sPanLen + rffrt_pkg::addrLen(sMode);
        hdrNow = (core_ff.st == rffrt_pkg::ST_HDR) &&
                 (core_ff.pos >= rffrt_pkg::HDR_BASE) &&
                 (core_ff.pos == hdrLen);
        hdrComplete = hdrNow || (core_ff.st == rffrt_pkg::ST_PAYLOAD);
    end

    rffrt_filter_decide u_decide (
        .hdr(core_ff.hdr),
        .cfg(cfg),
        .hdrComplete(hdrComplete),
        .fcsOk(rxIn.fcsOk),
        .verdict(verdict)
    );

    // ----------------------------------------------------------------
    // next state: registers, parser, events
    // ----------------------------------------------------------------
    always_comb begin
        logic [6:0] rel;
        rel = 7'h00;
        nxt_core = core_ff;
        nxt_core.rdValid = 1'b0;
        nxt_core.frameEnd = 1'b0;
        nxt_core.addrMatch = 1'b0;
        nxt_core.ackSend = 1'b0;

        // register write; unmapped offsets are ignored
        if (regReq.wr) begin
            if (regReq.addr == rffrt_pkg::ADDR_EXT_RX_CTRL) begin
                nxt_core.extRxCtrl = regReq.wdata &
                    rffrt_pkg::EXT_RX_CTRL_WMASK;
            end else if (regReq.addr == rffrt_pkg::ADDR_ACK_FILT_CTRL) begin
                nxt_core.ackFiltCtrl = regReq.wdata;
            end else if (regReq.addr == rffrt_pkg::ADDR_SHORT_LO) begin
                nxt_core.shortAddr[7:0] = regReq.wdata;
            end else if (regReq.addr == rffrt_pkg::ADDR_SHORT_HI) begin
                nxt_core.shortAddr[15:8] = regReq.wdata;
            end else if (regReq.addr == rffrt_pkg::ADDR_NETID_LO) begin
                nxt_core.panId[7:0] = regReq.wdata;
            end else if (regReq.addr == rffrt_pkg::ADDR_NETID_HI) begin
                nxt_core.panId[15:8] = regReq.wdata;
            end else if (isExtAddr(regReq.addr)) begin
                nxt_core.extAddr[extIndex(regReq.addr)*8 +: 8] =
                    regReq.wdata;
            end
        end

        // register read, answered one cycle later; unmapped reads zero
        if (regReq.rd) begin
            nxt_core.rdValid = 1'b1;
            if (regReq.addr == rffrt_pkg::ADDR_EXT_RX_CTRL) begin
                nxt_core.rdData = core_ff.extRxCtrl;
            end else if (regReq.addr == rffrt_pkg::ADDR_ACK_FILT_CTRL) begin
                nxt_core.rdData = core_ff.ackFiltCtrl;
            end else if (regReq.addr == rffrt_pkg::ADDR_SHORT_LO) begin
                nxt_core.rdData = core_ff.shortAddr[7:0];
            end else if (regReq.addr == rffrt_pkg::ADDR_SHORT_HI) begin
                nxt_core.rdData = core_ff.shortAddr[15:8];
            end else if (regReq.addr == rffrt_pkg::ADDR_NETID_LO) begin
                nxt_core.rdData = core_ff.panId[7:0];
            end else if (regReq.addr == rffrt_pkg::ADDR_NETID_HI) begin
                nxt_core.rdData = core_ff.panId[15:8];
            end else if (isExtAddr(regReq.addr)) begin
                nxt_core.rdData =
                    core_ff.extAddr[extIndex(regReq.addr)*8 +: 8];
            end else begin
                nxt_core.rdData = 8'h00;
            end
        end

        // frame parser; leaving the receive state aborts a frame, unless done arrives in the same cycle
        case (core_ff.st)
            rffrt_pkg::ST_IDLE: begin
                if (rxAackActive && rxIn.start) begin
                    nxt_core.st = rffrt_pkg::ST_HDR;
                    nxt_core.pos = 7'h00;
                    nxt_core.hdr = '0;
                end
            end
            rffrt_pkg::ST_HDR, rffrt_pkg::ST_PAYLOAD: begin
                if (hdrNow) begin
                    nxt_core.st = rffrt_pkg::ST_PAYLOAD;
                    nxt_core.addrMatch = verdict.amiOk;
                end
                if (rxIn.valid && (core_ff.pos < MAX_POS)) begin
                    nxt_core.pos = core_ff.pos + 7'h01;
                end
                // capture header bytes by position; source address dropped
                if (rxIn.valid && (core_ff.st == rffrt_pkg::ST_HDR) &&
                    !hdrNow) begin
                    if (core_ff.pos == 7'h00) begin
                        nxt_core.hdr.fcf[7:0] = rxIn.data;
                    end else if (core_ff.pos == 7'h01) begin
                        nxt_core.hdr.fcf[15:8] = rxIn.data;
                    end else if (core_ff.pos < rffrt_pkg::HDR_BASE) begin
                        rel = 7'h00; // sequence number is not filtered
                    end else if (core_ff.pos < dAddrStart) begin
                        rel = core_ff.pos - rffrt_pkg::HDR_BASE;
                        nxt_core.hdr.dstPan[rel[0]*8 +: 8] = rxIn.data;
                    end else if (core_ff.pos < sPanStart) begin
                        rel = core_ff.pos - dAddrStart;
                        nxt_core.hdr.dstAddr[rel[2:0]*8 +: 8] = rxIn.data;
                    end else if (core_ff.pos < sPanStart + sPanLen) begin
                        rel = core_ff.pos - sPanStart;
                        nxt_core.hdr.srcPan[rel[0]*8 +: 8] = rxIn.data;
                    end
                end
                if (rxIn.done) begin
                    // a short frame fails the filter but may still end
                    nxt_core.st = rffrt_pkg::ST_IDLE;
                    nxt_core.frameEnd = verdict.endOk;
                    nxt_core.ackSend = verdict.ackOk;
                    nxt_core.fcsValid = rxIn.fcsOk;
                end else if (!rxAackActive) begin
                    nxt_core.st = rffrt_pkg::ST_IDLE;
                    nxt_core.addrMatch = 1'b0;
                end else if (rxIn.start) begin
                    // restart on a new frame without a closing strobe
                    nxt_core.st = rffrt_pkg::ST_HDR;
                    nxt_core.pos = 7'h00;
                    nxt_core.hdr = '0;
                    nxt_core.addrMatch = 1'b0;
                end
            end
            default: begin
                nxt_core.st = rffrt_pkg::ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            core_ff <= '0;
            core_ff.st <= rffrt_pkg::ST_IDLE;
            core_ff.extRxCtrl <= rffrt_pkg::EXT_RX_CTRL_RST;
            core_ff.ackFiltCtrl <= rffrt_pkg::ACK_FILT_CTRL_RST;
            core_ff.shortAddr <= rffrt_pkg::SHORT_ADDR_RST;
            core_ff.panId <= rffrt_pkg::NETID_RST;
            core_ff.extAddr <= rffrt_pkg::EXT_ADDR_RST;
        end else begin
            core_ff <= nxt_core;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign regRdData = core_ff.rdData;
    assign regRdValid = core_ff.rdValid;
    assign frameEndEvent = core_ff.frameEnd;
    assign addrMatchEvent = core_ff.addrMatch;
    assign ackSend = core_ff.ackSend;
    assign rxFcsValid = core_ff.fcsValid;
    assign txTimestampEnable = core_ff.extRxCtrl[rffrt_pkg::BIT_TX_TS_EN];
    assign ackTurnaroundSelect = core_ff.extRxCtrl[rffrt_pkg::BIT_ACK_TIME];
    assign smartPowerEnable = core_ff.extRxCtrl[rffrt_pkg::BIT_SMART_PWR];
endmodule
